/* File: cdoc_pkg.sv */
package cdoc_pkg;
	localparam int NUM_CH = 10;
	localparam int CMP_CH_FIRST = 6;
	localparam int CMP_CH_COUNT = 4;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HALF_BITS = 5'h08;
	localparam logic [4:0] COUNT_MAX = 5'h1F;
	localparam int PAT_MSB = 15;
	localparam int PAT_LSB = 12;
	localparam int OPS_MSB = 7;
	localparam int HDR_PAT_MSB = 7;
	localparam int HDR_PAT_LSB = 4;
	localparam int HDR_SEL_MSB = 3;
	localparam logic [3:0] CMD_PATTERN = 4'h1;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_REG1 = 4'h1;
	localparam logic [3:0] SEL_REG2 = 4'h2;
	localparam logic [3:0] SEL_REG3 = 4'h3;
	localparam logic [1:0] MODE_SERIAL = 2'h0;
	localparam logic [1:0] MODE_PARALLEL = 2'h2;
	localparam logic [1:0] MODE_AND = 2'h3;
	localparam logic [19:0] MODE_RESET = 20'hA_AAAA;
	localparam logic [11:0] OUT_CTRL_RESET = 12'h0C00;
	localparam logic [1:0] OUT_FIXED_ONES = 2'h3;
	localparam logic [7:0] PIN_SET_RESET = 8'h0F;
	localparam logic [1:0] DIAG_OK = 2'h3;
	localparam logic [7:0] DIAG_ALL_OK = 8'hFF;
	localparam logic [1:0] REG2_ONES = 2'h3;
	localparam logic [7:0] DIAG_NONE = 8'h00;
	localparam logic [9:0] CLR_REG1 = 10'h00F;
	localparam logic [9:0] CLR_REG2 = 10'h030;
	localparam logic [9:0] CLR_REG3 = 10'h3C0;
endpackage : cdoc_pkg

/* File: diag_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
	logic [19:0] code;
	logic [19:0] sent;
	logic [9:0] clear;
	modport store (output code, input sent, input clear);
	modport reader (input code, output sent, output clear);
endinterface : diag_if
`default_nettype wire

/* File: diag_code_store.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_code_store import cdoc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Analogue diagnosis events
	input wire logic [9:0] event_in,
	input wire logic [19:0] code_in,
	// Link to the frame logic
	diag_if.store d
);
	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			logic [1:0] code;
			logic [1:0] next_code;
			// Newest event wins, also over a clear in the same cycle
			always_comb begin
				next_code = code;
				if (event_in[i]) begin
					next_code = code_in[2*i +: 2];
				end else if (d.clear[i] && code == d.sent[2*i +: 2]) begin
					// Only clear what was reported, so a later error survives
					next_code = DIAG_OK;
				end
			end
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					code <= DIAG_OK;
				end else begin
					code <= next_code;
				end
			end
			assign d.code[2*i +: 2] = code;
		end
	endgenerate
endmodule : diag_code_store
`default_nettype wire

/* File: compact_diag_output_control.sv */
`timescale 1ns/1ps
`default_nettype none
module compact_diag_output_control import cdoc_pkg::*; (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Serial port from the host
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic SI,
	output logic SO,
	output logic SO_OE,
	// Channel pins
	input wire logic [9:0] PAR_IN,
	output logic [9:0] CH_ON,
	// Diagnosis events from the output stages
	input wire logic [9:0] DIAG_EVENT,
	input wire logic [19:0] DIAG_CODE_IN,
	// Output control register contents
	output logic [11:0] OUT_CTRL
);
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_FRAME = 1'b1} state_e;

	diag_if d ();

	diag_code_store u_store (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.event_in(DIAG_EVENT),
		.code_in(DIAG_CODE_IN),
		.d(d)
	);

	state_e state, next_state;
	logic cs_q, sclk_q;
	logic [4:0] count, next_count;
	logic [15:0] rx, next_rx;
	logic [7:0] resp_hi, next_resp_hi;
	logic [7:0] diag_byte, next_diag_byte;
	logic [23:0] snap, next_snap;
	logic [3:0] sel, next_sel;
	logic [7:0] prev_ops, next_prev_ops;
	logic [19:0] mode, next_mode;
	logic [9:0] next_clear;
	logic [9:0] clear;
	logic next_so, next_so_oe;
	logic [11:0] next_out_ctrl;
	logic [9:0] next_ch_on;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall, frame_ok;
	logic [7:0] reg1, reg2, reg3, opf;

	// Pins are synchronous to REF_CLK, so edges come from one registered copy
	assign cs_fall = cs_q & ~CS_N;
	assign cs_rise = ~cs_q & CS_N;
	assign sclk_rise = ~sclk_q & SCLK;
	assign sclk_fall = sclk_q & ~SCLK;
	assign frame_ok = (count == FRAME_BITS) && (rx[PAT_MSB:PAT_LSB] == CMD_PATTERN);

	// Live diagnosis registers built from the stored channel codes
	assign reg1 = d.code[7:0];
	assign reg3 = d.code[19:12];
	assign reg2 = {reg1 != DIAG_ALL_OK, reg3 != DIAG_ALL_OK, REG2_ONES, d.code[11:8]};
	assign d.sent = {snap[23:16], snap[11:8], snap[7:0]};
	assign d.clear = clear;

	// Feedback: per channel, pin level if parallel, else the echoed on/off bit
	always_comb begin
		opf = {4'h0, prev_ops[3:0]};
		for (int i = 0; i < CMP_CH_COUNT; i++) begin
			opf[i + 4] = prev_ops[i] ? PAR_IN[CMP_CH_FIRST + i] : prev_ops[i + 4];
		end
	end

	// Frame sequencing, shifting and register updates
	always_comb begin
		next_state = state;
		next_count = count;
		next_rx = rx;
		next_so = SO;
		next_so_oe = SO_OE;
		next_resp_hi = resp_hi;
		next_diag_byte = diag_byte;
		next_snap = snap;
		next_sel = sel;
		next_prev_ops = prev_ops;
		next_mode = mode;
		next_out_ctrl = OUT_CTRL;
		next_clear = '0;
		unique case (state)
			ST_IDLE: begin
				if (cs_fall) begin
					next_state = ST_FRAME;
					next_count = '0;
					next_so_oe = 1'b1;
					next_resp_hi = opf;
					next_so = opf[7];
					next_snap = {reg3, reg2, reg1};
				end
			end
			ST_FRAME: begin
				if (cs_rise) begin
					next_state = ST_IDLE;
					next_so_oe = 1'b0;
					// Short, long or foreign frames change nothing
					if (frame_ok) begin
						next_prev_ops = rx[OPS_MSB:0];
						for (int i = 0; i < CMP_CH_COUNT; i++) begin
							next_mode[2*(CMP_CH_FIRST + i) +: 2] = rx[i] ? MODE_PARALLEL : MODE_SERIAL;
							next_out_ctrl[CMP_CH_FIRST + i] = rx[i + 4];
						end
						case (sel)
							SEL_REG1: next_clear = CLR_REG1;
							SEL_REG2: next_clear = CLR_REG2;
							SEL_REG3: next_clear = CLR_REG3;
							default: next_clear = '0;
						endcase
					end
				end else begin
					if (sclk_rise && count != COUNT_MAX) begin
						next_rx = {rx[14:0], SI};
						next_count = count + 5'h01;
						if (count == HALF_BITS - 5'h01) begin
							next_sel = (next_rx[HDR_PAT_MSB:HDR_PAT_LSB] == CMD_PATTERN) ?
								next_rx[HDR_SEL_MSB:0] : SEL_NONE;
							case (next_sel)
								SEL_REG1: next_diag_byte = snap[7:0];
								SEL_REG2: next_diag_byte = snap[15:8];
								SEL_REG3: next_diag_byte = snap[23:16];
								default: next_diag_byte = DIAG_NONE;
							endcase
						end
					end
					// Host samples on the rising edge, so the next bit goes out on the falling one
					if (sclk_fall && count != 5'h00 && count < FRAME_BITS) begin
						next_so = (count < HALF_BITS) ? resp_hi[3'h7 - count[2:0]] :
							diag_byte[3'h7 - count[2:0]];
					end
				end
			end
		endcase
	end

	// Channel drive: the on/off bit counts in every mode except parallel
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			unique case (mode[2*i +: 2])
				MODE_PARALLEL: next_ch_on[i] = PAR_IN[i];
				MODE_AND: next_ch_on[i] = PAR_IN[i] & OUT_CTRL[i];
				default: next_ch_on[i] = OUT_CTRL[i];
			endcase
		end
	end

	// State registers
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			cs_q <= 1'b1;
			sclk_q <= 1'b0;
			count <= '0;
			rx <= '0;
			resp_hi <= '0;
			diag_byte <= '0;
			snap <= {3{DIAG_ALL_OK}};
			sel <= SEL_NONE;
			prev_ops <= PIN_SET_RESET;
			mode <= MODE_RESET;
			clear <= '0;
			SO <= 1'b0;
			SO_OE <= 1'b0;
			OUT_CTRL <= OUT_CTRL_RESET;
			CH_ON <= '0;
		end else begin
			state <= next_state;
			cs_q <= CS_N;
			sclk_q <= SCLK;
			count <= next_count;
			rx <= next_rx;
			resp_hi <= next_resp_hi;
			diag_byte <= next_diag_byte;
			snap <= next_snap;
			sel <= next_sel;
			prev_ops <= next_prev_ops;
			mode <= next_mode;
			clear <= next_clear;
			SO <= next_so;
			SO_OE <= next_so_oe;
			OUT_CTRL <= {OUT_FIXED_ONES, next_out_ctrl[9:0]};
			CH_ON <= next_ch_on;
		end
	end

	// Checks
	oe_on_frame_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_IDLE && cs_fall) |=> SO_OE && SO == resp_hi[7]) else $error("SO not started at frame open");
	low_byte_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_FRAME && !cs_rise && sclk_fall && count == HALF_BITS) |=> SO == diag_byte[7])
		else $error("Low byte does not start with diagnosis");
	// Selector 0011: three bits already in rx, the last one on SI at this rise
	diag_select_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_FRAME && !cs_rise && sclk_rise && count == HALF_BITS - 5'h01 &&
		rx[2:0] == 3'h1 && SI && rx[6:3] == CMD_PATTERN)
		|=> diag_byte == snap[23:16]) else $error("Register 3 not selected");
	sum_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_IDLE && cs_fall) |=> snap[15] == (snap[7:0] != DIAG_ALL_OK) && snap[14] == (snap[23:16] != DIAG_ALL_OK))
		else $error("Summary flags wrong");
	par_feedback_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_IDLE && cs_fall && prev_ops[0]) |=> resp_hi[4] == $past(PAR_IN[6]))
		else $error("Parallel feedback not the pin level");
	ser_feedback_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_IDLE && cs_fall && !prev_ops[1]) |=> resp_hi[5] == $past(prev_ops[5]))
		else $error("Serial feedback not echoed");
	pin_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(state == ST_FRAME && cs_rise && frame_ok) |=> OUT_CTRL[9:6] == $past(rx[7:4]) && prev_ops == $past(rx[7:0]))
		else $error("Pin-set byte not applied");
	serial_drive_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(mode[13] == 1'b0) |=> CH_ON[6] == $past(OUT_CTRL[6])) else $error("Serial channel ignores on bit");
	par_drive_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(mode[13:12] == MODE_PARALLEL) |=> CH_ON[6] == $past(PAR_IN[6])) else $error("Parallel channel ignores pin");
	fixed_ones_a: assert property (@(posedge REF_CLK)
		!RST_N |=> OUT_CTRL[11:10] == OUT_FIXED_ONES && (!$past(RST_N) -> OUT_CTRL == OUT_CTRL_RESET))
		else $error("Output control reset or fixed bits wrong");
endmodule : compact_diag_output_control
`default_nettype wire

/* File: spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Clock
	input wire logic clk,
	// Serial lines
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so
);
	// Idle: deselected, serial clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// One mode-0 frame, MSB first; each phase spans two or more cycles for margin
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n <= 1'b0;
		si <= tx[15];
		repeat (3) @(posedge clk);
		for (int i = 15; i >= 0; i--) begin
			rx[i] = so;
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
			sclk <= 1'b0;
			if (i > 0) si <= tx[i-1];
			repeat (3) @(posedge clk);
		end
		cs_n <= 1'b1;
		// A released line must not keep showing the last bit
		si <= ~si;
		repeat (3) @(posedge clk);
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: compact_diag_output_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module compact_diag_output_control_tb import cdoc_pkg::*;;
	logic ref_clk, rst_n, cs_n, sclk, si, so, so_oe;
	logic [9:0] par_in, ch_on, diag_event;
	logic [19:0] diag_code_in;
	logic [11:0] out_ctrl;
	logic [15:0] rx;
	int miscompares, n_tests;
	// Device under test and the host that talks to it
	compact_diag_output_control dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SI(si),
		.SO(so), .SO_OE(so_oe), .PAR_IN(par_in), .CH_ON(ch_on), .DIAG_EVENT(diag_event),
		.DIAG_CODE_IN(diag_code_in), .OUT_CTRL(out_ctrl));
	spi_host_model host (.clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// Reset state: register value, idle output, channels on their pins
	task automatic test_reset;
		par_in <= 10'h2A5;
		repeat (2) @(posedge ref_clk);
		check("out_ctrl", {4'h0, out_ctrl}, {4'h0, OUT_CTRL_RESET});
		check("so_oe", {15'h0000, so_oe}, 16'h0000);
		check("ch_on", {6'h00, ch_on}, 16'h02A5);
		$display("test_reset done");
	endtask : test_reset
	// All four channels serial and on, then a mixed command with serial echo
	task automatic test_serial_mixed;
		host.xfer(16'h11F0, rx);
		check("diag1", rx[7:0], 8'hFF);
		check("out_ctrl", {4'h0, out_ctrl}, 16'h0FC0);
		check("ch_on", {6'h00, ch_on}, 16'h03E5);
		par_in <= 10'h07F;
		host.xfer(16'h13A5, rx);
		check("fb_serial", rx[15:8], 8'hF0);
		check("ch_on_mix", {6'h00, ch_on}, 16'h02FF);
		host.xfer(16'h1100, rx);
		check("fb_mixed", rx[15:8], 8'hB5);
		check("out_off", {4'h0, out_ctrl}, 16'h0C00);
		check("ch_on_off", {6'h00, ch_on}, 16'h003F);
		$display("test_serial_mixed done");
	endtask : test_serial_mixed
	// Errors on channels 1 and 8, read back through all three registers
	task automatic test_diag;
		diag_code_in <= 20'hD_FFFB;
		diag_event <= 10'h102;
		@(posedge ref_clk);
		diag_event <= 10'h000;
		@(posedge ref_clk);
		host.xfer(16'h1200, rx);
		check("diag2", rx[7:0], 8'hFF);
		host.xfer(16'h1100, rx);
		check("diag1", rx[7:0], 8'hFB);
		host.xfer(16'h1300, rx);
		check("diag3", rx[7:0], 8'hDF);
		host.xfer(16'h1200, rx);
		check("diag2_clr", rx[7:0], 8'h3F);
		$display("test_diag done");
	endtask : test_diag
	// An error raised inside a frame shows only in the next frame's snapshot
	task automatic test_snapshot;
		fork
			host.xfer(16'h1100, rx);
			begin
				repeat (6) @(posedge ref_clk);
				check("so_oe_on", {15'h0000, so_oe}, 16'h0001);
				diag_code_in <= 20'hF_FFFC;
				diag_event <= 10'h001;
				@(posedge ref_clk);
				diag_event <= 10'h000;
			end
		join
		check("diag1_snap", rx[7:0], 8'hFF);
		check("so_oe_off", {15'h0000, so_oe}, 16'h0000);
		host.xfer(16'h1100, rx);
		check("diag1_new", rx[7:0], 8'hFC);
		$display("test_snapshot done");
	endtask : test_snapshot
	// A frame with the wrong pattern changes nothing and returns zero
	task automatic test_refuse;
		host.xfer(16'h21F0, rx);
		check("diag_bad", rx[7:0], 8'h00);
		check("out_kept", {4'h0, out_ctrl}, 16'h0C00);
		check("ch_kept", {6'h00, ch_on}, 16'h003F);
		$display("test_refuse done");
	endtask : test_refuse
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		par_in = 10'h000;
		diag_event = 10'h000;
		diag_code_in = 20'hF_FFFF;
		miscompares = 0;
		n_tests = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		test_reset();
		test_serial_mixed();
		test_diag();
		test_snapshot();
		test_refuse();
		give_verdict();
	end
	// Watchdog: about a thousand cycles are needed, so twenty thousand means a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		give_verdict();
	end
endmodule : compact_diag_output_control_tb
`default_nettype wire
